// *** fsss_pkg.sv ***
// Package for the flash sector select and status block: map, fields, carriers
`default_nettype none
package fsss_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [21:0] IDX_SECT_LOW = 22'h0E0004;
  localparam logic [21:0] IDX_SECT_HIGH = 22'h0E0006;
  localparam logic [21:0] IDX_DATA_LOW = 22'h0E0008;
  localparam logic [21:0] IDX_CTRL = 22'h0E0020;
  localparam logic [21:0] IDX_IRQ_STAT = 22'h0E0021;
  localparam logic [21:0] IDX_IRQ_EN = 22'h0E0022;
  localparam logic [21:0] IDX_IRQ_CLR = 22'h0E0023;
  // Reset values
  localparam logic [15:0] RST_DATA_LOW = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  // Sector field widths and bank status positions in the high register
  localparam int B2_W = 3;
  localparam int B0_W = 10;
  localparam int HI_W = 2;
  localparam int POS_HI_BANK_LO = 8;
  localparam int POS_HI_BANK_HI = 9;
  // Control register bit positions
  localparam int POS_START = 0;
  localparam int POS_ERASE = 1;
  localparam int POS_SUSPEND_REQUEST = 2;
  localparam int POS_VIEW = 3;
  localparam int POS_BUSY = 8;
  localparam int POS_ERR = 9;
  localparam int POS_SUSPENDED = 10;
  // Interrupt event positions
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_SUSPEND_REQUEST = 2;
  localparam int EV_W = 3;
  // One bank pair of one module: low bank sectors, high bank sectors, bank bits
  typedef struct packed {
    logic [B0_W-1:0] lo_sect;
    logic [HI_W-1:0] hi_sect;
    logic lo_bank;
    logic hi_bank;
  } fsss_view_s;
  // Answer from the flash engine
  typedef struct packed {
    logic done;
    logic error;
    logic suspend_request_ack;
  } fsss_evt_s;
  // Command to the flash engine
  typedef struct packed {
    logic start;
    logic erase;
    logic module_main;
    logic suspend;
  } fsss_cmd_s;
endpackage : fsss_pkg
`default_nettype wire

// *** fsss_top.sv ***
// Sector select/status registers, program data low word, engine handshake, IRQ
//
// Added by the designer: the Avalon-MM register port.
`default_nettype none
module fsss_top
  import fsss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [23:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire fsss_evt_s eng_evt,
  output fsss_cmd_s eng_cmd_ff,
  output logic [B0_W-1:0] eng_sectors_lo,
  output logic [HI_W-1:0] eng_sectors_hi,
  output logic [15:0] prog_data_low,
  output logic irq
);

  // Merge of 16 write bits under the two low byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [3:0] be);
    merge16 = old_v;
    if (be[0]) begin
      merge16[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = new_v[15:8];
    end
  endfunction : merge16

  // Pack one view into the low sector register image
  function automatic logic [15:0] low_img(input fsss_view_s v, input logic main_sel);
    low_img = RST_ZERO16;
    if (main_sel) begin
      low_img[B0_W-1:0] = v.lo_sect;
    end else begin
      low_img[B2_W-1:0] = v.lo_sect[B2_W-1:0];
    end
  endfunction : low_img

  // Pack one view into the high sector register image
  function automatic logic [15:0] high_img(input fsss_view_s v);
    high_img = RST_ZERO16;
    high_img[HI_W-1:0] = v.hi_sect;
    high_img[POS_HI_BANK_LO] = v.lo_bank;
    high_img[POS_HI_BANK_HI] = v.hi_bank;
  endfunction : high_img

  logic waitreq_ff;
  logic [31:0] rdata_ff;
  fsss_view_s ext_ff;
  fsss_view_s main_ff;
  logic [15:0] data_low_ff;
  logic view_main_ff;
  logic start_ff;
  logic erase_sel_ff;
  logic suspend_request_req_ff;
  logic busy_ff;
  logic err_ff;
  logic suspended_ff;
  logic op_main_ff;
  logic op_erase_ff;
  logic [EV_W-1:0] irq_stat_ff;
  logic [EV_W-1:0] irq_en_ff;
  logic irq_ff;
  logic [B0_W-1:0] sect_lo_ff;
  logic [HI_W-1:0] sect_hi_ff;

  logic [21:0] idx;
  logic acc;
  logic wr_acc;
  logic [15:0] wd;
  logic ctl_wr;
  logic start_req;
  logic resume_req;
  logic launch;
  logic clean_end;
  logic err_end;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] clr_mask;
  logic [31:0] nxt_rdata;
  fsss_view_s sel_view;
  logic [15:0] lo_merge;
  logic [15:0] hi_merge;

  assign idx = avs_address[23:2];
  assign acc = (avs_read | avs_write) & ~waitreq_ff;
  assign wr_acc = avs_write & ~waitreq_ff;
  assign wd = avs_writedata[15:0];
  assign sel_view = view_main_ff ? main_ff : ext_ff;
  // Byte-merged images of the visible view; a function result cannot be sliced in place
  assign lo_merge = merge16(low_img(sel_view, view_main_ff), wd, avs_byteenable);
  assign hi_merge = merge16(high_img(sel_view), wd, avs_byteenable);
  assign ctl_wr = wr_acc & (idx == IDX_CTRL) & avs_byteenable[0];
  // Start refused while busy, while an error stands or with suspend asked
  assign start_req = ctl_wr & wd[POS_START] & ~wd[POS_SUSPEND_REQUEST] & ~busy_ff & ~err_ff;
  assign resume_req = start_req & suspended_ff;
  assign launch = start_req;
  assign clean_end = busy_ff & eng_evt.done & ~eng_evt.error;
  assign err_end = busy_ff & eng_evt.done & eng_evt.error;
  assign events = {busy_ff & eng_evt.suspend_request_ack, err_end, clean_end};
  assign clr_mask = (wr_acc & (idx == IDX_IRQ_CLR) & avs_byteenable[0]) ? wd[EV_W-1:0] : '0;

  // One wait cycle per access: request seen, then completed with waitrequest low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~((avs_read | avs_write) & waitreq_ff);
    end
  end

  // Read mux; unmapped and write-only locations read zero
  always_comb begin
    nxt_rdata = '0;
    case (idx)
      IDX_SECT_LOW: nxt_rdata[15:0] = low_img(sel_view, view_main_ff);
      IDX_SECT_HIGH: nxt_rdata[15:0] = high_img(sel_view);
      IDX_DATA_LOW: nxt_rdata[15:0] = data_low_ff;
      IDX_CTRL: begin
        nxt_rdata[POS_START] = start_ff;
        nxt_rdata[POS_ERASE] = erase_sel_ff;
        nxt_rdata[POS_SUSPEND_REQUEST] = suspend_request_req_ff;
        nxt_rdata[POS_VIEW] = view_main_ff;
        nxt_rdata[POS_BUSY] = busy_ff;
        nxt_rdata[POS_ERR] = err_ff;
        nxt_rdata[POS_SUSPENDED] = suspended_ff;
      end
      IDX_IRQ_STAT: nxt_rdata[EV_W-1:0] = irq_stat_ff;
      IDX_IRQ_EN: nxt_rdata[EV_W-1:0] = irq_en_ff;
      default: nxt_rdata = '0;
    endcase
  end

  // Read data latched in the wait cycle, stands at the completing edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= '0;
    end else if (avs_read & waitreq_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Program data low word, plain storage for the program engine
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_low_ff <= RST_DATA_LOW;
    end else if (wr_acc & (idx == IDX_DATA_LOW)) begin
      data_low_ff <= merge16(data_low_ff, wd, avs_byteenable);
    end
  end

  // Software control bits; start cannot be cleared by software
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      view_main_ff <= 1'b0;
      erase_sel_ff <= 1'b0;
      suspend_request_req_ff <= 1'b0;
    end else begin
      if (ctl_wr) begin
        view_main_ff <= wd[POS_VIEW];
        suspend_request_req_ff <= wd[POS_SUSPEND_REQUEST];
      end
      // Erase select dropped at the end of the operation, which wins over a write
      if (busy_ff & eng_evt.done) begin
        erase_sel_ff <= 1'b0;
      end else if (ctl_wr & ~busy_ff) begin
        erase_sel_ff <= wd[POS_ERASE];
      end
    end
  end

  // Operation state: start bit, busy, error flag, suspended flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_ff <= 1'b0;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      suspended_ff <= 1'b0;
      op_main_ff <= 1'b0;
      op_erase_ff <= 1'b0;
    end else begin
      if (launch) begin
        start_ff <= 1'b1;
        busy_ff <= 1'b1;
        suspended_ff <= 1'b0;
        if (!resume_req) begin
          op_main_ff <= wd[POS_VIEW];
          op_erase_ff <= wd[POS_ERASE];
        end
      end else if (busy_ff & (eng_evt.done | eng_evt.suspend_request_ack)) begin
        start_ff <= 1'b0;
        busy_ff <= 1'b0;
        suspended_ff <= ~eng_evt.done & eng_evt.suspend_request_ack;
      end
      // Set wins over the software clear of the error flag
      if (err_end) begin
        err_ff <= 1'b1;
      end else if (ctl_wr & wd[POS_ERR]) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Sector and bank bits of both modules; each view keeps its own storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_ff <= '0;
      main_ff <= '0;
    end else if (launch & wd[POS_ERASE] & ~resume_req) begin
      // Erase start: bank bits follow the banks holding selected sectors
      if (wd[POS_VIEW]) begin
        main_ff.lo_bank <= |main_ff.lo_sect;
        main_ff.hi_bank <= |main_ff.hi_sect;
      end else begin
        ext_ff.lo_bank <= |ext_ff.lo_sect[B2_W-1:0];
        ext_ff.hi_bank <= |ext_ff.hi_sect;
      end
    end else if (clean_end) begin
      // Clean end wipes the module that was operated on
      if (op_main_ff) begin
        main_ff <= '0;
      end else begin
        ext_ff <= '0;
      end
    end else if (wr_acc & ~busy_ff & (idx == IDX_SECT_LOW)) begin
      // Software sector select; reserved bits dropped
      if (view_main_ff) begin
        main_ff.lo_sect <= lo_merge[B0_W-1:0];
      end else begin
        ext_ff.lo_sect <= {{(B0_W-B2_W){1'b0}}, lo_merge[B2_W-1:0]};
      end
    end else if (wr_acc & ~busy_ff & (idx == IDX_SECT_HIGH)) begin
      // Sector bits of the upper bank only; bank bits are device owned
      if (view_main_ff) begin
        main_ff.hi_sect <= hi_merge[HI_W-1:0];
      end else begin
        ext_ff.hi_sect <= hi_merge[HI_W-1:0];
      end
    end
  end

  // Command and selected sectors to the engine, from flip-flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      eng_cmd_ff <= '0;
      sect_lo_ff <= '0;
      sect_hi_ff <= '0;
    end else begin
      eng_cmd_ff.start <= launch;
      if (launch) begin
        eng_cmd_ff.erase <= resume_req ? op_erase_ff : wd[POS_ERASE];
        eng_cmd_ff.module_main <= resume_req ? op_main_ff : wd[POS_VIEW];
        sect_lo_ff <= (resume_req ? op_main_ff : wd[POS_VIEW]) ? main_ff.lo_sect : ext_ff.lo_sect;
        sect_hi_ff <= (resume_req ? op_main_ff : wd[POS_VIEW]) ? main_ff.hi_sect : ext_ff.hi_sect;
      end
      // Suspend only reaches the engine while an operation runs
      eng_cmd_ff.suspend <= busy_ff & (ctl_wr ? wd[POS_SUSPEND_REQUEST] : suspend_request_req_ff);
    end
  end

  // Interrupt status: sticky, set wins over clear; enable gates the line
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~clr_mask) | events;
      if (wr_acc & (idx == IDX_IRQ_EN) & avs_byteenable[0]) begin
        irq_en_ff <= wd[EV_W-1:0];
      end
      irq_ff <= |(((irq_stat_ff & ~clr_mask) | events) & irq_en_ff);
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign eng_sectors_lo = sect_lo_ff;
  assign eng_sectors_hi = sect_hi_ff;
  assign prog_data_low = data_low_ff;
  assign irq = irq_ff;

endmodule : fsss_top
`default_nettype wire

// *** fsss_checker.sv ***
// Checker for bus timing, engine command and reset values of the sector block
`default_nettype none
module fsss_checker
  import fsss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [23:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire fsss_evt_s eng_evt,
  input wire fsss_cmd_s eng_cmd_ff,
  input wire logic [B0_W-1:0] eng_sectors_lo,
  input wire logic [15:0] prog_data_low,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic busy_ff;
  logic ctrl_wr;
  logic data_wr;
  // Completed writes to the control and data registers
  assign ctrl_wr = avs_write && !avs_waitrequest && avs_address[23:2] == IDX_CTRL;
  assign data_wr = avs_write && !avs_waitrequest && avs_address[23:2] == IDX_DATA_LOW;
  // Busy rebuilt from the engine side, since the body is not visible here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) busy_ff <= 1'b0;
    else if (eng_cmd_ff.start) busy_ff <= 1'b1;
    else if (eng_evt.done || eng_evt.suspend_request_ack) busy_ff <= 1'b0;
  end
  AST_WAIT_ANSWER: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after request");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_READ_UPPER: assert property (!avs_waitrequest && avs_read |->
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  AST_START_PULSE: assert property (eng_cmd_ff.start |=> !eng_cmd_ff.start)
    else $error("start longer than one cycle");
  AST_START_CAUSE: assert property (eng_cmd_ff.start |-> $past(ctrl_wr) && !busy_ff)
    else $error("start without a control write or while busy");
  AST_START_VIEW: assert property (eng_cmd_ff.start |->
    eng_cmd_ff.module_main == $past(avs_writedata[POS_VIEW]))
    else $error("module select differs from view bit");
  AST_SECT_LATCH: assert property ($changed(eng_sectors_lo) |-> eng_cmd_ff.start)
    else $error("sector selection moved outside a start");
  AST_PDATA: assert property ($changed(prog_data_low) |-> $past(data_wr))
    else $error("program data moved without a write");
  AST_RESET_VALUES: assert property (!$past(reset_n) |-> !irq && prog_data_low == 16'hFFFF)
    else $error("wrong value after reset");
endmodule : fsss_checker
`default_nettype wire

// *** fsss_top_tb.sv ***
// Testbench for the sector select, status and program data registers
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module fsss_top_tb
  import fsss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] avs_address = 24'h000000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  fsss_evt_s eng_evt = '0;
  fsss_cmd_s eng_cmd_ff;
  logic [B0_W-1:0] eng_sectors_lo;
  logic [HI_W-1:0] eng_sectors_hi;
  logic [15:0] prog_data_low;
  logic irq;
  logic [15:0] q;
  logic hit;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  fsss_top fsss_top_inst (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .eng_evt,
    .eng_cmd_ff, .eng_sectors_lo, .eng_sectors_hi, .prog_data_low, .irq);
  always #2 ref_clk = ~ref_clk;
  // Hang guard: whole run needs under two hundred cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic [21:0] idx, input logic w, input logic [15:0] d);
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rc(input logic [21:0] idx, input logic [15:0] e);
    bus(idx, 1'b0, 16'h0000);
    `CHK(q, e)
  endtask : rc
  // Wait a bounded time for an engine start pulse
  task automatic ws();
    hit = 1'b0;
    for (int i = 0; i < 12 && !hit; i++) begin
      @(posedge ref_clk);
      hit = (eng_cmd_ff.start === 1'b1);
    end
  endtask : ws
  // Engine answers are one-cycle pulses
  task automatic ev(input fsss_evt_s e);
    @(posedge ref_clk);
    eng_evt <= e;
    @(posedge ref_clk);
    eng_evt <= '0;
  endtask : ev
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rc(IDX_SECT_LOW, 16'h0000);
    rc(IDX_SECT_HIGH, 16'h0000);
    rc(IDX_DATA_LOW, 16'hFFFF);
    bus(IDX_DATA_LOW, 1'b1, 16'hA5C3);
    rc(IDX_DATA_LOW, 16'hA5C3);
    `CHK(prog_data_low, 16'hA5C3)
    // Views keep separate bits; reserved and status bits drop writes
    bus(IDX_SECT_LOW, 1'b1, 16'hFFFF);
    rc(IDX_SECT_LOW, 16'h0007);
    bus(IDX_SECT_HIGH, 1'b1, 16'hFFFF);
    rc(IDX_SECT_HIGH, 16'h0003);
    bus(IDX_CTRL, 1'b1, 16'h0008);
    rc(IDX_SECT_LOW, 16'h0000);
    bus(IDX_SECT_LOW, 1'b1, 16'hFFFF);
    rc(IDX_SECT_LOW, 16'h03FF);
    bus(IDX_SECT_HIGH, 1'b1, 16'hFFFD);
    rc(IDX_SECT_HIGH, 16'h0001);
    // Clean main erase clears only that module and raises the done irq
    bus(IDX_IRQ_EN, 1'b1, 16'h0001);
    bus(IDX_CTRL, 1'b1, 16'h000B);
    ws();
    `CHK({hit, eng_cmd_ff.erase, eng_cmd_ff.module_main}, 3'b111)
    `CHK({eng_sectors_lo, eng_sectors_hi}, 12'hFFD)
    rc(IDX_SECT_HIGH, 16'h0301);
    rc(IDX_SECT_LOW, 16'h03FF);
    ev(3'h4);
    rc(IDX_SECT_LOW, 16'h0000);
    rc(IDX_SECT_HIGH, 16'h0000);
    `CHK(irq, 1'b1)
    rc(IDX_IRQ_STAT, 16'h0001);
    bus(IDX_IRQ_CLR, 1'b1, 16'h0001);
    rc(IDX_IRQ_STAT, 16'h0000);
    `CHK(irq, 1'b0)
    // Extension erase with error keeps status; error irq is masked
    bus(IDX_CTRL, 1'b1, 16'h0003);
    ws();
    `CHK({hit, eng_cmd_ff.module_main}, 2'b10)
    ev(3'h6);
    rc(IDX_SECT_LOW, 16'h0007);
    rc(IDX_SECT_HIGH, 16'h0303);
    bus(IDX_CTRL, 1'b0, 16'h0000);
    `CHK({q[9], irq}, 2'b10)
    rc(IDX_IRQ_STAT, 16'h0002);
    bus(IDX_CTRL, 1'b1, 16'h0003);
    ws();
    `CHK(hit, 1'b0)
    bus(IDX_CTRL, 1'b1, 16'h0200);
    bus(IDX_IRQ_CLR, 1'b1, 16'h0002);
    // Suspend, then resume to a clean end
    bus(IDX_CTRL, 1'b1, 16'h0003);
    ws();
    bus(IDX_CTRL, 1'b1, 16'h0006);
    repeat (2) @(posedge ref_clk);
    `CHK(eng_cmd_ff.suspend, 1'b1)
    ev(3'h1);
    bus(IDX_CTRL, 1'b0, 16'h0000);
    `CHK(q[10:9], 2'b10)
    rc(IDX_SECT_LOW, 16'h0007);
    bus(IDX_CTRL, 1'b1, 16'h0003);
    ws();
    `CHK(hit, 1'b1)
    ev(3'h4);
    rc(IDX_SECT_LOW, 16'h0000);
    // Unmapped place reads zero and keeps nothing
    bus(22'h0E0030, 1'b1, 16'hFFFF);
    rc(22'h0E0030, 16'h0000);
    // Program start: no erase to the engine, data word still held for it
    bus(IDX_CTRL, 1'b1, 16'h0001);
    ws();
    `CHK({hit, eng_cmd_ff.erase, prog_data_low}, {2'b10, 16'hA5C3})
    ev(3'h4);
    rc(IDX_SECT_LOW, 16'h0000);
    stop_test();
  end
endmodule : fsss_top_tb
bind fsss_top fsss_checker fsss_checker_inst (.ref_clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .eng_evt, .eng_cmd_ff,
  .eng_sectors_lo, .prog_data_low, .irq);
`default_nettype wire
